// [adc_thr_pkg.sv]
// constants, types and field layouts of the threshold and port-enable
// command handler; assumes byte-wide command frames and 10-bit samples
// Function
// - threshold set code 0x30,0x38 carries four 4-digit ASCII thresholds
// - thresholds decide ON/OFF only while the input is in switch mode
// - ON at threshold plus 8 or more, OFF at threshold minus 8 or less
// - thresholds above 1015 turn on from 1015; below 8, off up to 8
// - threshold reply code 0x30,0x39: flag then four stored thresholds
// - threshold reply flag: 0x30 accepted, 0x31 run mode, 0x39 failed
// - threshold query 0x31,0x30 with dummy byte, reply flag always 0x30
// - thresholds default to 0000
// - port-enable set code 0x31,0x31 with 34 record bytes
// - record bytes 1-4 pick level 0x31 or switch 0x32 per analog input
// - record byte 6 picks the ADC reference 0x30, 0x31 or 0x32
// - commas 0x2C expected exactly at record bytes 5,7,12,17,22,27,32
// - remaining record bytes enable 0x31 or disable 0x32 inputs and outputs
// - reset and factory reset enable all ports, analog inputs in level mode
// - port-enable reply code 0x31,0x32: flag then the 34-byte record
// - port-enable query 0x31,0x33 with dummy byte, answered with normal flag
// - queries answer in the same frame format as the matching set reply
// - set commands act only in setting mode; queries work in both modes
// - reported control state is 0x31 in setting mode, 0x30 in run mode
package adc_thr_pkg;
	localparam int N_ADC = 4;
	localparam int N_IN = 12;
	localparam int N_OUT = 10;
	localparam int N_DIG = 4;
	localparam int SAMP_W = 10;
	localparam int NUM_W = 14;

	localparam logic [7:0] CH_0 = 8'h30;
	localparam logic [7:0] CH_9 = 8'h39;
	localparam logic [7:0] CH_SEP = 8'h2C;
	localparam logic [15:0] CODE_THR_SET = 16'h3038;
	localparam logic [15:0] CODE_THR_REPLY = 16'h3039;
	localparam logic [15:0] CODE_THR_QUERY = 16'h3130;
	localparam logic [15:0] CODE_PE_SET = 16'h3131;
	localparam logic [15:0] CODE_PE_REPLY = 16'h3132;
	localparam logic [15:0] CODE_PE_QUERY = 16'h3133;
	localparam logic [7:0] FLAG_OK = 8'h30;
	localparam logic [7:0] FLAG_RUN = 8'h31;
	localparam logic [7:0] FLAG_NG = 8'h39;
	localparam logic [7:0] MODE_LEVEL = 8'h31;
	localparam logic [7:0] MODE_SWITCH = 8'h32;
	localparam logic [7:0] REF_AVCC = 8'h30;
	localparam logic [7:0] REF_EXT = 8'h32;
	localparam logic [7:0] PORT_EN = 8'h31;
	localparam logic [7:0] PORT_DIS = 8'h32;
	localparam logic [7:0] STATE_SETTING = 8'h31;
	localparam logic [7:0] STATE_RUN = 8'h30;

	localparam logic [5:0] THR_SET_LEN = 6'h10;
	localparam logic [5:0] THR_REPLY_LEN = 6'h11;
	localparam logic [5:0] PE_SET_LEN = 6'h22;
	localparam logic [5:0] PE_REPLY_LEN = 6'h23;
	localparam logic [5:0] QUERY_LEN = 6'h01;
	localparam logic [5:0] CODE_LEN = 6'h02;
	localparam logic [5:0] IDX_CODE_HI = 6'h00;
	localparam logic [5:0] IDX_CODE_LO = 6'h01;
	localparam logic [5:0] IDX_FLAG = 6'h02;
	localparam logic [5:0] REC_BASE = 6'h03;

	// zero-based record positions
	localparam logic [5:0] POS_MODE_END = 6'h04;
	localparam logic [5:0] POS_REF = 6'h05;
	localparam logic [5:0] IN_G0 = 6'h07;
	localparam logic [5:0] IN_G1 = 6'h0C;
	localparam logic [5:0] IN_G2 = 6'h11;
	localparam logic [5:0] OUT_G0 = 6'h16;
	localparam logic [5:0] OUT_G1 = 6'h1B;
	localparam logic [5:0] OUT_G2 = 6'h20;
	localparam logic [5:0] GRP = 6'h04;

	localparam logic [SAMP_W-1:0] HYST = 10'h008;
	localparam logic [SAMP_W-1:0] ON_CAP = 10'h3F7;
	localparam logic [SAMP_W-1:0] OFF_FLOOR = 10'h008;
	localparam logic [NUM_W-1:0] THR_MAX = 14'h03FF;
	localparam logic [NUM_W-1:0] W1000 = 14'h03E8;
	localparam logic [NUM_W-1:0] W100 = 14'h0064;
	localparam logic [NUM_W-1:0] W10 = 14'h000A;

	localparam logic [N_IN-1:0] IN_EN_RST = 12'hFFF;
	localparam logic [N_OUT-1:0] OUT_EN_RST = 10'h3FF;
	localparam logic [N_ADC-1:0] MODE_RST = 4'h0;
	localparam logic [1:0] REF_RST = 2'h0;

	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_THR01 = 8'h08;
	localparam logic [7:0] ADDR_THR23 = 8'h0C;
	localparam logic [7:0] ADDR_ENABLE = 8'h10;
	localparam int CTRL_SETTING_BIT = 0;
	localparam int CTRL_FRESET_BIT = 1;

	typedef enum logic [2:0] {k_mode, k_sep, k_ref, k_in, k_out} pkind_e;
	typedef struct packed {
		pkind_e kind;
		logic [3:0] port;
	} pos_s;

	function automatic pos_s pos_decode(input logic [5:0] p);
		pos_s r;
		logic [5:0] o;
		o = 6'h00;
		r.kind = k_sep;
		if (p < POS_MODE_END)
		begin
			r.kind = k_mode;
			o = p;
		end
		else if (p == POS_REF)
			r.kind = k_ref;
		else if (p >= IN_G0 && p < IN_G0 + GRP)
		begin
			r.kind = k_in;
			o = p - IN_G0;
		end
		else if (p >= IN_G1 && p < IN_G1 + GRP)
		begin
			r.kind = k_in;
			o = p - IN_G1 + GRP;
		end
		else if (p >= IN_G2 && p < IN_G2 + GRP)
		begin
			r.kind = k_in;
			o = p - IN_G2 + GRP + GRP;
		end
		else if (p >= OUT_G0 && p < OUT_G0 + GRP)
		begin
			r.kind = k_out;
			o = p - OUT_G0;
		end
		else if (p >= OUT_G1 && p < OUT_G1 + GRP)
		begin
			r.kind = k_out;
			o = p - OUT_G1 + GRP;
		end
		else if (p >= OUT_G2 && p < PE_SET_LEN)
		begin
			r.kind = k_out;
			o = p - OUT_G2 + GRP + GRP;
		end
		r.port = o[3:0];
		return r;
	endfunction
endpackage

// [adc_cmp_if.sv]
// bundle between the command handler and the hysteresis comparator
// assumes one clock domain on both sides
`timescale 1ns/1ps
interface adc_cmp_if;
	logic [adc_thr_pkg::N_ADC-1:0][adc_thr_pkg::SAMP_W-1:0] thr;
	logic [adc_thr_pkg::N_ADC-1:0][adc_thr_pkg::SAMP_W-1:0] sample;
	logic [adc_thr_pkg::N_ADC-1:0] switch_mode;
	logic sample_valid;
	wire [adc_thr_pkg::N_ADC-1:0] state;
	modport ctl (output thr, output sample, output switch_mode,
		output sample_valid, input state);
	modport cmp (input thr, input sample, input switch_mode,
		input sample_valid, output state);
endinterface

// [adc_hyst_cmp.sv]
// per-input hysteresis comparator with registered ON/OFF state
// assumes thresholds are stable binary values from the handler
`timescale 1ns/1ps
module adc_hyst_cmp (
	input wire logic clock,
	input wire logic rst_n,
	adc_cmp_if.cmp cif
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);

	for (genvar c = 0; c < adc_thr_pkg::N_ADC; c++)
	begin : g_ch
		logic [adc_thr_pkg::SAMP_W-1:0] on_lvl;
		logic [adc_thr_pkg::SAMP_W-1:0] off_lvl;
		logic st_d;
		logic st_q;

		always_comb
		begin
			// capped so a threshold near full scale can still turn on
			if (cif.thr[c] > adc_thr_pkg::ON_CAP)
				on_lvl = adc_thr_pkg::ON_CAP;
			else
				on_lvl = cif.thr[c] + adc_thr_pkg::HYST;
			if (cif.thr[c] < adc_thr_pkg::OFF_FLOOR)
				off_lvl = adc_thr_pkg::OFF_FLOOR;
			else
				off_lvl = cif.thr[c] - adc_thr_pkg::HYST;
			st_d = st_q;
			if (!cif.switch_mode[c])
				st_d = 1'b0;
			else if (cif.sample_valid)
			begin
				if (cif.sample[c] >= on_lvl)
					st_d = 1'b1;
				else if (cif.sample[c] <= off_lvl)
					st_d = 1'b0;
			end
		end

		always_ff @(posedge clock or negedge rst_n)
		begin
			if (!rst_n)
				st_q <= 1'b0;
			else
				st_q <= st_d;
		end

		assign cif.state[c] = st_q;

		a_switch_on: assert property (
			cif.switch_mode[c] && cif.sample_valid
			&& cif.sample[c] >= on_lvl |=> st_q)
			else $error("switch input stayed off above upper level");
		a_switch_off: assert property (
			cif.switch_mode[c] && cif.sample_valid
			&& cif.sample[c] <= off_lvl |=> !st_q)
			else $error("switch input stayed on below lower level");
		a_level_mode_off: assert property (
			!cif.switch_mode[c] |=> !st_q)
			else $error("level input reported a switch state");
		a_band_hold: assert property (
			cif.switch_mode[c] && cif.sample[c] < on_lvl
			&& cif.sample[c] > off_lvl && $stable(cif.thr[c])
			|=> $stable(st_q))
			else $error("state changed inside the hysteresis band");
	end
endmodule

// [adc_threshold_port_enable_cmd.sv]
// threshold and port-enable command handler with apb control registers
// assumes byte streams with valid/ready handshakes and synchronous inputs
`timescale 1ns/1ps
module adc_threshold_port_enable_cmd (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic rx_valid,
	input wire logic [7:0] rx_data,
	output logic rx_ready,
	output logic tx_valid,
	output logic [7:0] tx_data,
	input wire logic tx_ready,
	input wire logic [3:0][9:0] adc_sample,
	input wire logic adc_sample_valid,
	output logic [3:0] switch_state,
	output logic [3:0] adc_switch_mode,
	output logic [1:0] adc_ref_sel,
	output logic [11:0] input_enable,
	output logic [9:0] output_enable,
	output logic setting_mode
);
	typedef enum {st_code_hi, st_code_lo, st_data, st_reply} frame_e;
	typedef enum {cmd_thr_set, cmd_thr_query, cmd_pe_set, cmd_pe_query} cmd_e;
	typedef logic [3:0][3:0][3:0] digits_t;
	typedef logic [3:0][9:0] thr_t;

	frame_e st_d, st_q;
	cmd_e cmd_d, cmd_q;
	logic [7:0] code_hi_d, code_hi_q;
	logic [5:0] idx_d, idx_q;
	logic err_d, err_q;
	digits_t stg_dig_d, stg_dig_q, thr_dig_d, thr_dig_q;
	logic [3:0] stg_mode_d, stg_mode_q, mode_d, mode_q;
	logic [1:0] stg_ref_d, stg_ref_q, ref_d, ref_q;
	logic [11:0] stg_in_d, stg_in_q, in_en_d, in_en_q;
	logic [9:0] stg_out_d, stg_out_q, out_en_d, out_en_q;
	logic [7:0] flag_d, flag_q, tx_data_d, tx_data_q;
	logic tx_valid_d, tx_valid_q, rx_ready_d, rx_ready_q;
	thr_t thr_d, thr_q, stg_thr;
	logic take, frame_end, byte_err, err_now, commit_thr, commit_pe;
	logic is_set, is_thr;
	logic [5:0] last_idx;
	logic setting_d, setting_q, freset;
	logic pready_d, pready_q, pslverr_d, pslverr_q, access, done;
	logic [31:0] prdata_d, prdata_q;
	adc_thr_pkg::pos_s pd;

	adc_cmp_if cif ();
	assign cif.thr = thr_q;
	assign cif.sample = adc_sample;
	assign cif.switch_mode = mode_q;
	assign cif.sample_valid = adc_sample_valid;
	adc_hyst_cmp u_cmp (
		.clock(clock),
		.rst_n(rst_n),
		.cif(cif.cmp)
	);

	assign take = rx_valid && rx_ready_q;
	assign is_set = (cmd_q == cmd_thr_set) || (cmd_q == cmd_pe_set);
	assign is_thr = (cmd_q == cmd_thr_set) || (cmd_q == cmd_thr_query);

	function automatic logic [5:0] data_len(input cmd_e c);
		if (c == cmd_thr_set)
			return adc_thr_pkg::THR_SET_LEN;
		else if (c == cmd_pe_set)
			return adc_thr_pkg::PE_SET_LEN;
		return adc_thr_pkg::QUERY_LEN;
	endfunction

	function automatic logic [13:0] dec_val(input logic [3:0][3:0] d);
		return adc_thr_pkg::W1000 * {10'h000, d[0]}
			+ adc_thr_pkg::W100 * {10'h000, d[1]}
			+ adc_thr_pkg::W10 * {10'h000, d[2]} + {10'h000, d[3]};
	endfunction

	// query and set replies share this one builder
	function automatic logic [7:0] reply_byte(input logic [5:0] i);
		logic [5:0] p;
		adc_thr_pkg::pos_s q;
		logic [7:0] b;
		logic [15:0] code;
		p = i - adc_thr_pkg::REC_BASE;
		q = adc_thr_pkg::pos_decode(p);
		code = is_thr ? adc_thr_pkg::CODE_THR_REPLY
			: adc_thr_pkg::CODE_PE_REPLY;
		b = adc_thr_pkg::CH_SEP;
		if (i == adc_thr_pkg::IDX_CODE_HI)
			b = code[15:8];
		else if (i == adc_thr_pkg::IDX_CODE_LO)
			b = code[7:0];
		else if (i == adc_thr_pkg::IDX_FLAG)
			b = flag_q;
		else if (is_thr)
			b = adc_thr_pkg::CH_0 | {4'h0, thr_dig_q[p[3:2]][p[1:0]]};
		else
		begin
			case (q.kind)
				adc_thr_pkg::k_mode:
					b = mode_q[q.port[1:0]] ? adc_thr_pkg::MODE_SWITCH
						: adc_thr_pkg::MODE_LEVEL;
				adc_thr_pkg::k_ref:
					b = adc_thr_pkg::CH_0 | {6'h00, ref_q};
				adc_thr_pkg::k_in:
					b = in_en_q[q.port] ? adc_thr_pkg::PORT_EN
						: adc_thr_pkg::PORT_DIS;
				adc_thr_pkg::k_out:
					b = out_en_q[q.port] ? adc_thr_pkg::PORT_EN
						: adc_thr_pkg::PORT_DIS;
				default:
					b = adc_thr_pkg::CH_SEP;
			endcase
		end
		return b;
	endfunction

	always_comb
	begin
		st_d = st_q;
		cmd_d = cmd_q;
		code_hi_d = code_hi_q;
		idx_d = idx_q;
		err_d = err_q;
		stg_dig_d = stg_dig_q;
		stg_mode_d = stg_mode_q;
		stg_ref_d = stg_ref_q;
		stg_in_d = stg_in_q;
		stg_out_d = stg_out_q;
		flag_d = flag_q;
		tx_valid_d = tx_valid_q;
		tx_data_d = tx_data_q;
		byte_err = 1'b0;
		err_now = 1'b0;
		frame_end = 1'b0;
		commit_thr = 1'b0;
		commit_pe = 1'b0;
		stg_thr = '0;
		last_idx = data_len(cmd_q) - 6'h01;
		pd = adc_thr_pkg::pos_decode(idx_q);
		case (st_q)
			st_code_hi:
				if (take)
				begin
					code_hi_d = rx_data;
					st_d = st_code_lo;
				end
			st_code_lo:
				if (take)
				begin
					idx_d = '0;
					err_d = 1'b0;
					st_d = st_data;
					case ({code_hi_q, rx_data})
						adc_thr_pkg::CODE_THR_SET: cmd_d = cmd_thr_set;
						adc_thr_pkg::CODE_THR_QUERY: cmd_d = cmd_thr_query;
						adc_thr_pkg::CODE_PE_SET: cmd_d = cmd_pe_set;
						adc_thr_pkg::CODE_PE_QUERY: cmd_d = cmd_pe_query;
						default: st_d = st_code_hi;
					endcase
				end
			st_data:
				if (take)
				begin
					if (cmd_q == cmd_thr_set)
					begin
						if (rx_data >= adc_thr_pkg::CH_0
							&& rx_data <= adc_thr_pkg::CH_9)
							stg_dig_d[idx_q[3:2]][idx_q[1:0]] = rx_data[3:0];
						else
							byte_err = 1'b1;
					end
					else if (cmd_q == cmd_pe_set)
					begin
						case (pd.kind)
							adc_thr_pkg::k_mode:
								if (rx_data == adc_thr_pkg::MODE_LEVEL)
									stg_mode_d[pd.port[1:0]] = 1'b0;
								else if (rx_data == adc_thr_pkg::MODE_SWITCH)
									stg_mode_d[pd.port[1:0]] = 1'b1;
								else
									byte_err = 1'b1;
							adc_thr_pkg::k_ref:
								if (rx_data >= adc_thr_pkg::REF_AVCC
									&& rx_data <= adc_thr_pkg::REF_EXT)
									stg_ref_d = rx_data[1:0];
								else
									byte_err = 1'b1;
							adc_thr_pkg::k_in:
								if (rx_data == adc_thr_pkg::PORT_EN)
									stg_in_d[pd.port] = 1'b1;
								else if (rx_data == adc_thr_pkg::PORT_DIS)
									stg_in_d[pd.port] = 1'b0;
								else
									byte_err = 1'b1;
							adc_thr_pkg::k_out:
								if (rx_data == adc_thr_pkg::PORT_EN)
									stg_out_d[pd.port] = 1'b1;
								else if (rx_data == adc_thr_pkg::PORT_DIS)
									stg_out_d[pd.port] = 1'b0;
								else
									byte_err = 1'b1;
							default:
								byte_err = (rx_data != adc_thr_pkg::CH_SEP);
						endcase
					end
					err_now = err_q | byte_err;
					for (int c = 0; c < adc_thr_pkg::N_ADC; c++)
					begin
						logic [13:0] v;
						v = dec_val(stg_dig_d[c]);
						stg_thr[c] = v[9:0];
						// judge a channel only once its four digits are in,
						// so leftovers of a refused frame cannot poison it
						if (cmd_q == cmd_thr_set && c == int'(idx_q[3:2])
							&& (&idx_q[1:0]) && v > adc_thr_pkg::THR_MAX)
							err_now = 1'b1;
					end
					err_d = err_now;
					idx_d = idx_q + 6'h01;
					if (idx_q == last_idx)
					begin
						frame_end = 1'b1;
						flag_d = adc_thr_pkg::FLAG_OK;
						if (is_set && !setting_q)
							flag_d = adc_thr_pkg::FLAG_RUN;
						else if (is_set && err_now)
							flag_d = adc_thr_pkg::FLAG_NG;
						else
						begin
							commit_thr = (cmd_q == cmd_thr_set);
							commit_pe = (cmd_q == cmd_pe_set);
						end
						idx_d = '0;
						st_d = st_reply;
						tx_valid_d = 1'b1;
						tx_data_d = reply_byte(adc_thr_pkg::IDX_CODE_HI);
					end
				end
			st_reply:
				if (tx_valid_q && tx_ready)
				begin
					if (idx_q == adc_thr_pkg::CODE_LEN - 6'h01
						+ (is_thr ? adc_thr_pkg::THR_REPLY_LEN
						: adc_thr_pkg::PE_REPLY_LEN))
					begin
						tx_valid_d = 1'b0;
						st_d = st_code_hi;
					end
					else
					begin
						idx_d = idx_q + 6'h01;
						tx_data_d = reply_byte(idx_q + 6'h01);
					end
				end
			default:
				st_d = st_code_hi;
		endcase
		// receiving is stalled while a reply is still going out
		rx_ready_d = (st_d != st_reply);
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st_q <= st_code_hi;
			cmd_q <= cmd_thr_query;
			code_hi_q <= 8'h00;
			idx_q <= 6'h00;
			err_q <= 1'b0;
			stg_dig_q <= '0;
			stg_mode_q <= adc_thr_pkg::MODE_RST;
			stg_ref_q <= adc_thr_pkg::REF_RST;
			stg_in_q <= adc_thr_pkg::IN_EN_RST;
			stg_out_q <= adc_thr_pkg::OUT_EN_RST;
			flag_q <= adc_thr_pkg::FLAG_OK;
			tx_valid_q <= 1'b0;
			tx_data_q <= 8'h00;
			rx_ready_q <= 1'b0;
		end
		else
		begin
			st_q <= st_d;
			cmd_q <= cmd_d;
			code_hi_q <= code_hi_d;
			idx_q <= idx_d;
			err_q <= err_d;
			stg_dig_q <= stg_dig_d;
			stg_mode_q <= stg_mode_d;
			stg_ref_q <= stg_ref_d;
			stg_in_q <= stg_in_d;
			stg_out_q <= stg_out_d;
			flag_q <= flag_d;
			tx_valid_q <= tx_valid_d;
			tx_data_q <= tx_data_d;
			rx_ready_q <= rx_ready_d;
		end
	end

	// factory reset wins over a commit landing in the same cycle
	always_comb
	begin
		thr_dig_d = thr_dig_q;
		thr_d = thr_q;
		mode_d = mode_q;
		ref_d = ref_q;
		in_en_d = in_en_q;
		out_en_d = out_en_q;
		if (freset)
		begin
			thr_dig_d = '0;
			thr_d = '0;
			mode_d = adc_thr_pkg::MODE_RST;
			ref_d = adc_thr_pkg::REF_RST;
			in_en_d = adc_thr_pkg::IN_EN_RST;
			out_en_d = adc_thr_pkg::OUT_EN_RST;
		end
		else
		begin
			if (commit_thr)
			begin
				thr_dig_d = stg_dig_d;
				thr_d = stg_thr;
			end
			if (commit_pe)
			begin
				mode_d = stg_mode_d;
				ref_d = stg_ref_d;
				in_en_d = stg_in_d;
				out_en_d = stg_out_d;
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			thr_dig_q <= '0;
			thr_q <= '0;
			mode_q <= adc_thr_pkg::MODE_RST;
			ref_q <= adc_thr_pkg::REF_RST;
			in_en_q <= adc_thr_pkg::IN_EN_RST;
			out_en_q <= adc_thr_pkg::OUT_EN_RST;
		end
		else
		begin
			thr_dig_q <= thr_dig_d;
			thr_q <= thr_d;
			mode_q <= mode_d;
			ref_q <= ref_d;
			in_en_q <= in_en_d;
			out_en_q <= out_en_d;
		end
	end

	// one wait state keeps read data and pready straight from flops
	assign access = psel && penable;
	assign done = access && pready_q;
	assign freset = done && pwrite && paddr == adc_thr_pkg::ADDR_CTRL
		&& pwdata[adc_thr_pkg::CTRL_FRESET_BIT];

	always_comb
	begin
		pready_d = access && !pready_q;
		prdata_d = '0;
		pslverr_d = 1'b0;
		setting_d = setting_q;
		if (access && !pready_q)
		begin
			case (paddr)
				adc_thr_pkg::ADDR_CTRL:
					prdata_d = {31'h00000000, setting_q};
				adc_thr_pkg::ADDR_STATUS:
					prdata_d = {14'h0000, ref_q, mode_q, cif.state,
						setting_q ? adc_thr_pkg::STATE_SETTING
						: adc_thr_pkg::STATE_RUN};
				adc_thr_pkg::ADDR_THR01:
					prdata_d = {6'h00, thr_q[1], 6'h00, thr_q[0]};
				adc_thr_pkg::ADDR_THR23:
					prdata_d = {6'h00, thr_q[3], 6'h00, thr_q[2]};
				adc_thr_pkg::ADDR_ENABLE:
					prdata_d = {6'h00, out_en_q, 4'h0, in_en_q};
				default:
					pslverr_d = 1'b1;
			endcase
		end
		if (done && pwrite && paddr == adc_thr_pkg::ADDR_CTRL)
			setting_d = pwdata[adc_thr_pkg::CTRL_SETTING_BIT];
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pready_q <= 1'b0;
			prdata_q <= 32'h00000000;
			pslverr_q <= 1'b0;
			setting_q <= 1'b0;
		end
		else
		begin
			pready_q <= pready_d;
			prdata_q <= prdata_d;
			pslverr_q <= pslverr_d;
			setting_q <= setting_d;
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign rx_ready = rx_ready_q;
	assign tx_valid = tx_valid_q;
	assign tx_data = tx_data_q;
	assign switch_state = cif.state;
	assign adc_switch_mode = mode_q;
	assign adc_ref_sel = ref_q;
	assign input_enable = in_en_q;
	assign output_enable = out_en_q;
	assign setting_mode = setting_q;

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);

	sequence s_set_in_run;
		frame_end && is_set && !setting_q;
	endsequence
	sequence s_set_bad;
		frame_end && is_set && setting_q && err_now;
	endsequence
	sequence s_reply_open;
		$rose(tx_valid_q);
	endsequence

	a_run_flag: assert property (
		s_set_in_run |=> flag_q == adc_thr_pkg::FLAG_RUN)
		else $error("set in run mode did not give run flag");
	a_run_keeps_cfg: assert property (
		s_set_in_run and !freset |=> $stable(thr_q) && $stable(in_en_q))
		else $error("set in run mode changed settings");
	a_bad_rejected: assert property (
		s_set_bad and !freset
		|=> flag_q == adc_thr_pkg::FLAG_NG && $stable(thr_q)
		&& $stable(mode_q) && $stable(out_en_q))
		else $error("malformed set frame was not rejected");
	a_query_flag_ok: assert property (
		frame_end && !is_set |=> flag_q == adc_thr_pkg::FLAG_OK)
		else $error("query reply flag not normal");
	a_thr_commit: assert property (
		frame_end && cmd_q == cmd_thr_set && setting_q && !err_now
		&& !freset |=> thr_q == $past(stg_thr)
		&& flag_q == adc_thr_pkg::FLAG_OK)
		else $error("accepted threshold not stored");
	a_reply_code: assert property (
		s_reply_open and is_thr
		|-> tx_data_q == adc_thr_pkg::CODE_THR_REPLY[15:8]
		##1 tx_data_q == ($past(tx_ready)
		? adc_thr_pkg::CODE_THR_REPLY[7:0]
		: adc_thr_pkg::CODE_THR_REPLY[15:8]))
		else $error("threshold reply code wrong");
	a_freset_defaults: assert property (
		freset |=> in_en_q == adc_thr_pkg::IN_EN_RST
		&& out_en_q == adc_thr_pkg::OUT_EN_RST
		&& mode_q == adc_thr_pkg::MODE_RST && thr_q == '0)
		else $error("factory reset did not restore defaults");
	a_apb_wait: assert property (
		access && !pready_q |=> pready_q ##1 !pready_q)
		else $error("apb answer not exactly one wait state");
	a_rx_stall: assert property (
		frame_end |=> !rx_ready_q [*2])
		else $error("receive not stalled during reply");
endmodule

// [cmd_host.sv]
// host model: sends command frames and collects reply bytes
// assumes valid/ready byte handshakes on the handler's clock
`timescale 1ns/1ps
module cmd_host (
	input wire logic clock,
	output logic rx_valid,
	output logic [7:0] rx_data,
	input wire logic rx_ready,
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	output logic tx_ready
);
	logic [7:0] rsp[$];
	logic slow = 1'b0;
	initial
	begin
		rx_valid = 1'b0;
		rx_data = 8'hA5;
		tx_ready = 1'b0;
	end
	// slow mode drops tx_ready every other cycle so held replies get exercised
	always @(posedge clock)
	begin
		if (tx_valid && tx_ready)
			rsp.push_back(tx_data);
		tx_ready <= slow ? !tx_ready : 1'b1;
	end
	task automatic send(input logic [7:0] f[$]);
		foreach (f[i])
		begin
			rx_valid <= 1'b1;
			rx_data <= f[i];
			@(posedge clock);
			while (!rx_ready)
				@(posedge clock);
		end
		rx_valid <= 1'b0;
		// a released line must not keep showing the last byte
		rx_data <= ~f[f.size()-1];
	endtask
endmodule

// [adc_threshold_port_enable_cmd_tb.sv]
// self-checking bench for the threshold and port-enable handler
// assumes cmd_host as the far side and a 100 MHz clock
`timescale 1ns/1ps
module adc_threshold_port_enable_cmd_tb;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, q;
	logic pready, pslverr, rx_valid, rx_ready, tx_valid, tx_ready, e;
	logic [7:0] rx_data, tx_data;
	logic [3:0][9:0] adc_sample = '0;
	logic adc_sample_valid = 1'b0;
	logic [3:0] switch_state, adc_switch_mode;
	logic [1:0] adc_ref_sel;
	logic [11:0] input_enable;
	logic [9:0] output_enable;
	logic setting_mode;
	int n_mismatch = 0;
	int comparisons = 0;
	logic [7:0] f[$], x[$];
	always #5 clock = ~clock;
	adc_threshold_port_enable_cmd dut (.*);
	cmd_host host (.*);
	task automatic chk(input string s, input logic [31:0] g, exp);
		comparisons++;
		if (g !== exp)
		begin
			$display("BAD %s exp %h got %h", s, exp, g);
			n_mismatch++;
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input int d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		@(posedge clock);
		while (pready !== 1'b1)
			@(posedge clock);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
	endtask
	task automatic dig(ref logic [7:0] d[$], input int v);
		for (int k = 1000; k > 0; k /= 10)
			d.push_back(8'(8'h30 + (v / k) % 10));
	endtask
	task automatic thr_frame(input logic [7:0] fl, input int v[4], w[4]);
		f = '{8'h30, 8'h38};
		x = '{8'h30, 8'h39, fl};
		foreach (v[i])
		begin
			dig(f, v[i]);
			dig(x, w[i]);
		end
	endtask
	task automatic pe_frame(input logic [7:0] fl);
		f = '{8'h31, 8'h31, 8'h32, 8'h31, 8'h31, 8'h31, 8'h2C, 8'h31};
		for (int i = 0; i < 22; i++)
		begin
			if (i % 4 == 0)
				f.push_back(8'h2C);
			f.push_back((i == 0 || i == 21) ? 8'h32 : 8'h31);
		end
		x = f;
		x[1] = 8'h32;
		x.insert(2, fl);
	endtask
	task automatic xfer(input string s);
		int n;
		host.rsp.delete();
		host.send(f);
		n = 0;
		while (host.rsp.size() < x.size() && n < 500)
		begin
			@(posedge clock);
			n++;
		end
		repeat (2) @(posedge clock);
		chk(s, host.rsp.size(), x.size());
		foreach (x[i])
			chk(s, host.rsp[i], x[i]);
	endtask
	task automatic t_reset;
		chk("in en", input_enable, 12'hFFF);
		chk("out en", output_enable, 10'h3FF);
		chk("setting", setting_mode, 1'b0);
		apb(1'b0, 8'h04, 0);
		chk("ctl state", q[7:0], 8'h30);
		apb(1'b0, 8'h08, 0);
		chk("thr01", q, 32'h0);
		apb(1'b0, 8'h40, 0);
		chk("slverr", e, 1'b1);
	endtask
	task automatic t_thr;
		thr_frame(8'h31, '{100, 1023, 5, 500}, '{0, 0, 0, 0});
		xfer("run set");
		apb(1'b1, 8'h00, 1);
		chk("setting", setting_mode, 1'b1);
		apb(1'b0, 8'h04, 0);
		chk("ctl state", q[7:0], 8'h31);
		host.slow = 1'b1;
		thr_frame(8'h30, '{100, 1023, 5, 500}, '{100, 1023, 5, 500});
		xfer("thr set");
		host.slow = 1'b0;
		f = '{8'h31, 8'h30, 8'h30};
		xfer("thr query");
		thr_frame(8'h39, '{1024, 0, 0, 0}, '{100, 1023, 5, 500});
		xfer("thr range");
		thr_frame(8'h39, '{0, 0, 0, 0}, '{100, 1023, 5, 500});
		f[3] = 8'h41;
		xfer("thr digit");
		apb(1'b0, 8'h08, 0);
		chk("thr01", q, 32'h03FF0064);
	endtask
	task automatic t_pe;
		pe_frame(8'h30);
		xfer("pe set");
		chk("modes", adc_switch_mode, 4'h1);
		chk("ref", adc_ref_sel, 2'h1);
		chk("in en", input_enable, 12'hFFE);
		chk("out en", output_enable, 10'h1FF);
		f = '{8'h31, 8'h33, 8'h30};
		xfer("pe query");
		pe_frame(8'h39);
		f[6] = 8'h31;
		xfer("pe sep");
		// an unknown code is dropped whole; the query behind it still answers
		f = '{8'h32, 8'h32, 8'h31, 8'h33, 8'h30};
		x[2] = 8'h30;
		xfer("pe code");
	endtask
	task automatic samp(input int v, input logic exp);
		adc_sample[0] <= 10'(v);
		adc_sample_valid <= 1'b1;
		repeat (3) @(posedge clock);
		chk("switch", switch_state, {3'b000, exp});
	endtask
	task automatic t_cmp;
		samp(107, 1'b0);
		samp(108, 1'b1);
		samp(93, 1'b1);
		samp(92, 1'b0);
		apb(1'b1, 8'h00, 3);
		chk("in en", input_enable, 12'hFFF);
		chk("modes", adc_switch_mode, 4'h0);
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// input two stays in level mode at full scale and must read OFF
	initial
	begin
		adc_sample[1] = 10'h3FF;
		repeat (4) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		t_reset;
		t_thr;
		t_pe;
		t_cmp;
		report_and_stop;
	end
	initial
	begin
		#100000;
		n_mismatch++;
		report_and_stop;
	end
endmodule
